/* File: design/clock_sync_serial_channel.sv */
`timescale 1ns/1ps
`include "clock_sync_serial_consts.svh"
// ==========================================
// Notes on behaviour
// [RQ1] Every frame carries exactly eight data bits.
// [RQ2] Internal shift clock is source clock over 2(m+1), m from divisor register.
// [RQ3] Source is undivided, divide-by-8, or prescaled (none for n=0, else 2n).
// [RQ4] Clock source select 1 takes the clock pin as input; 0 uses divider.
// [RQ5] Handshake is clear-to-send, request-to-send, or none.
// [RQ6] Transmit starts on enable, buffer full and, if selected, clear-to-send low.
// [RQ7] Receive starts only with receive enable, transmit enable and buffer full.
// [RQ8] Peer holds external clock high for edge select 0, low for 1.
// [RQ9] Edge select 0 drives on falling, samples on rising; 1 the reverse.
// [RQ10] Cause select 0: transmit interrupt as buffer moves into shift register.
// [RQ11] Cause select 1: transmit interrupt when shift register finishes.
// [RQ12] Receive interrupt when a finished word enters the receive buffer.
// [RQ13] Overrun flag sets when seventh bit arrives before buffer is read.
// [RQ14] On overrun no receive interrupt; buffer contents undefined.
// [RQ15] Bit order select picks bit 0 first or bit 7 first.
// [RQ16] Continuous receive starts next word on a receive buffer read.
// [RQ17] Invert bit inverts transmitted bits and received buffer data.
// [RQ18] In continuous receive a buffer read clears the buffer empty flag.
// [RQ19] Software writes no dummy words while continuous receive is on.
// [RQ20] Serial output idles high, or floats when open drain is chosen.
// [RQ21] Receive-full sets on load, clears on read; shift-empty when idle.
// [RQ22] Internal clock is driven on the pin, idling per edge select.
module clock_sync_serial_channel
  import clock_sync_serial_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe_o,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe_o,
  input  wire logic        serial_in_pin_i,
  input  wire logic        cts_n_i,
  output logic             rts_n_o,
  output logic             tx_irq_o,
  output logic             rx_irq_o
);
  // ==========================================
  // Registers
  logic [7:0]     tbuf_q;
  logic [7:0]     rbuf_q;
  logic [7:0]     brg_q;
  logic [3:0]     presc_q;
  logic [1:0]     cks_q;
  logic           cksrc_q;
  logic           crs_q;
  logic           crd_q;
  logic           od_q;
  logic           edge_q;
  logic           order_q;
  logic           te_q;
  logic           tbe_q;
  logic           re_q;
  logic           rxf_q;
  logic           irs_q;
  logic           cont_q;
  logic           inv_q;
  logic           ovr_q;
  logic           ack_q;
  logic [31:0]    dat_q;
  xfer_state_type st_q;
  logic [2:0]     bit_q;
  logic [7:0]     tx_sh_q;
  logic [7:0]     rx_sh_q;
  logic           rx_act_q;
  logic           ovr_w_q;
  logic           sclk_q;
  logic           txd_q;
  logic           sclk_oe_q;
  logic           sout_q;
  logic           soe_q;
  logic           rts_q;
  logic           txi_q;
  logic           rxi_q;
  logic           tick;
  logic           p_rise;
  logic           p_fall;

  // ==========================================
  // Bus decode
  wire logic acc    = wb_cyc_i & wb_stb_i & ~ack_q;
  wire logic wr     = acc & wb_we_i & wb_sel_i[0];
  wire logic rd     = acc & ~wb_we_i;
  wire logic hit_tx = wb_adr_i == `CSS_ADR_TXBUF;
  wire logic hit_rx = wb_adr_i == `CSS_ADR_RXBUF;
  wire logic hit_br = wb_adr_i == `CSS_ADR_BRG;
  wire logic hit_md = wb_adr_i == `CSS_ADR_MODE;
  wire logic hit_c0 = wb_adr_i == `CSS_ADR_CTRL0;
  wire logic hit_c1 = wb_adr_i == `CSS_ADR_CTRL1;
  wire logic hit_ps = wb_adr_i == `CSS_ADR_PRESC;
  wire logic rx_rd  = rd & hit_rx;
  wire logic busy   = st_q != ST_IDLE;
  wire logic sh_emp = ~busy; // RQ21

  wire logic [31:0] rdata =
    hit_tx ? {24'h0, tbuf_q} :
    hit_rx ? {23'h0, ovr_q, rbuf_q} :
    hit_br ? {24'h0, brg_q} :
    hit_md ? {31'h0, cksrc_q} :
    hit_c0 ? {24'h0, order_q, edge_q, od_q, crd_q, sh_emp, crs_q, cks_q} :
    hit_c1 ? {25'h0, inv_q, cont_q, irs_q, rxf_q, re_q, tbe_q, te_q} :
    hit_ps ? {28'h0, presc_q} : 32'h0;

  // ==========================================
  // Start, clock events and data paths
  // Clear-to-send only gates when enabled and selected
  wire logic cts_ok = crd_q | crs_q | ~cts_n_i; // RQ5
  wire logic start  = (st_q == ST_IDLE) & te_q & ~tbe_q & cts_ok; // RQ6
  wire logic idle_l = ~edge_q;
  wire logic i_drv  = tick & (sclk_q == idle_l);
  wire logic i_smp  = tick & (sclk_q != idle_l);
  wire logic e_drv  = edge_q ? p_rise : p_fall; // RQ9
  wire logic e_smp  = edge_q ? p_fall : p_rise; // RQ9
  wire logic shift  = st_q == ST_SHIFT;
  wire logic drv    = shift & (cksrc_q ? e_drv : i_drv); // RQ4
  wire logic smp    = shift & (cksrc_q ? e_smp : i_smp); // RQ4
  wire logic last   = smp & (bit_q == `CSS_LAST_BIT); // RQ1
  wire logic ovr_s  = smp & (bit_q == `CSS_OVR_BIT) & rx_act_q & rxf_q; // RQ13
  wire logic done   = st_q == ST_DONE;
  wire logic [7:0] tx_v = tbuf_q ^ {8{inv_q}}; // RQ17
  logic      [7:0] tx_rev;
  logic      [7:0] rx_rev;
  // Bit reversal serves MSB-first in both directions
  for (genvar gi = 0; gi < 8; gi++) begin : g_rev
    assign tx_rev[gi] = tx_v[7 - gi];
    assign rx_rev[gi] = rx_sh_q[7 - gi];
  end
  wire logic [7:0] tx_l = order_q ? tx_rev : tx_v; // RQ15
  wire logic [7:0] rx_o = order_q ? rx_rev : rx_sh_q; // RQ15
  wire logic [7:0] rx_v = rx_o ^ {8{inv_q}}; // RQ17

  clk_src_div u_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (shift & ~cksrc_q),
    .src_i   (cks_q),
    .presc_i (presc_q),
    .div_i   (brg_q),
    .tick_o  (tick)
  );

  pin_edge_detect u_edge (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (serial_clock_pin_i),
    .rise_o  (p_rise),
    .fall_o  (p_fall)
  );

  // ==========================================
  // Software-written configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brg_q   <= `CSS_RST_BYTE;
      presc_q <= 4'h0;
      cksrc_q <= 1'b0;
      {order_q, edge_q, od_q, crs_q, cks_q} <= 6'h00;
      crd_q   <= `CSS_RST_CRD;
      {inv_q, cont_q, irs_q, re_q, te_q} <= 5'h00;
    end else if (wr) begin
      if (hit_br) brg_q <= wb_dat_i[7:0];
      if (hit_ps) presc_q <= wb_dat_i[3:0];
      if (hit_md) cksrc_q <= wb_dat_i[`CSS_MD_CKSRC];
      if (hit_c0) begin
        cks_q   <= wb_dat_i[`CSS_C0_CKS_HI:`CSS_C0_CKS_LO];
        crs_q   <= wb_dat_i[`CSS_C0_CRS];
        crd_q   <= wb_dat_i[`CSS_C0_CRD];
        od_q    <= wb_dat_i[`CSS_C0_OD];
        edge_q  <= wb_dat_i[`CSS_C0_EDGE];
        order_q <= wb_dat_i[`CSS_C0_ORDER];
      end
      if (hit_c1) begin
        te_q   <= wb_dat_i[`CSS_C1_TE];
        re_q   <= wb_dat_i[`CSS_C1_RE];
        irs_q  <= wb_dat_i[`CSS_C1_IRS];
        cont_q <= wb_dat_i[`CSS_C1_CONT];
        inv_q  <= wb_dat_i[`CSS_C1_INV];
      end
    end
  end

  // ==========================================
  // Bus answer: ack one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= acc;
      if (rd) dat_q <= rdata;
    end
  end

  // ==========================================
  // Status flags; a hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbuf_q <= `CSS_RST_BYTE;
      tbe_q  <= 1'b1;
      rxf_q  <= 1'b0;
      ovr_q  <= 1'b0;
      rbuf_q <= `CSS_RST_BYTE;
    end else begin
      if (wr && hit_tx) begin
        tbuf_q <= wb_dat_i[7:0];
        tbe_q  <= 1'b0;
      end
      if (rx_rd && cont_q) tbe_q <= 1'b0; // RQ16 RQ18
      if (start) tbe_q <= 1'b1;
      if (rx_rd) rxf_q <= 1'b0; // RQ21
      if (done && rx_act_q) begin
        rbuf_q <= rx_v; // RQ14
        rxf_q  <= 1'b1; // RQ21
      end
      if (!re_q) ovr_q <= 1'b0;
      if (ovr_s) ovr_q <= 1'b1; // RQ13
    end
  end

  // ==========================================
  // Transfer sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q     <= ST_IDLE;
      bit_q    <= 3'h0;
      rx_act_q <= 1'b0;
      ovr_w_q  <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            st_q     <= ST_SHIFT;
            bit_q    <= 3'h0;
            rx_act_q <= re_q; // RQ7
            ovr_w_q  <= 1'b0;
          end
        end
        ST_SHIFT: begin
          if (smp) bit_q <= bit_q + 3'h1;
          if (ovr_s) ovr_w_q <= 1'b1;
          if (last) st_q <= ST_DONE; // RQ1
        end
        ST_DONE: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Shift registers and line levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      txd_q   <= 1'b1;
    end else begin
      if (start) tx_sh_q <= tx_l;
      else if (drv) tx_sh_q <= {1'b0, tx_sh_q[7:1]};
      if (drv) txd_q <= tx_sh_q[0]; // RQ9
      else if (done) txd_q <= 1'b1; // RQ20
      if (smp) rx_sh_q <= {serial_in_pin_i, rx_sh_q[7:1]}; // RQ9
    end
  end

  // Internal clock toggles once per divider tick and ends at idle level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_q <= 1'b1;
    end else if (!busy) begin
      sclk_q <= idle_l; // RQ22
    end else if (tick && !cksrc_q) begin
      sclk_q <= ~sclk_q; // RQ2
    end
  end

  // ==========================================
  // Registered outputs; pins lag their source state by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_oe_q <= 1'b0;
      sout_q    <= 1'b1;
      soe_q     <= 1'b1;
      rts_q     <= 1'b1;
      txi_q     <= 1'b0;
      rxi_q     <= 1'b0;
    end else begin
      sclk_oe_q <= ~cksrc_q; // RQ22
      sout_q    <= ~od_q & txd_q; // RQ20
      soe_q     <= ~od_q | ~txd_q; // RQ20
      rts_q     <= ~(~crd_q & crs_q & re_q & ~rxf_q); // RQ5
      txi_q     <= irs_q ? done : start; // RQ10 RQ11
      rxi_q     <= done & rx_act_q & ~ovr_w_q; // RQ12 RQ14
    end
  end

  assign wb_ack_o              = ack_q;
  assign wb_dat_o              = dat_q;
  assign serial_clock_pin_o    = sclk_q;
  assign serial_clock_pin_oe_o = sclk_oe_q;
  assign serial_out_pin_o      = sout_q;
  assign serial_out_pin_oe_o   = soe_q;
  assign rts_n_o               = rts_q;
  assign tx_irq_o              = txi_q;
  assign rx_irq_o              = rxi_q;

  // ==========================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  word_len_a: assert property ( // RQ1
    shift && smp && bit_q == 3'h7 |=> st_q == ST_DONE ##1 st_q == ST_IDLE)
    else $error("word did not end after eighth bit");
  tx_start_a: assert property ( // RQ6
    st_q == ST_SHIFT && $past(st_q) == ST_IDLE |-> $past(te_q && !tbe_q && cts_ok))
    else $error("transfer started without start condition");
  rx_start_a: assert property ( // RQ7
    $rose(rx_act_q) |-> $past(re_q && te_q && !tbe_q))
    else $error("reception started without enables");
  clk_idle_a: assert property ( // RQ22
    !busy && !cksrc_q |=> serial_clock_pin_o == ~$past(edge_q) && serial_clock_pin_oe_o)
    else $error("internal clock not at idle level");
  tx_irq0_a: assert property ( // RQ10
    start && !irs_q |=> tx_irq_o && tbe_q)
    else $error("transmit interrupt missing at load");
  tx_irq1_a: assert property ( // RQ11
    done && irs_q |=> tx_irq_o ##1 !tx_irq_o)
    else $error("transmit interrupt missing at completion");
  rx_irq_a: assert property ( // RQ12
    rx_irq_o |-> rxf_q && $past(done && !ovr_w_q))
    else $error("receive interrupt without loaded word");
  overrun_a: assert property ( // RQ13
    ovr_s |=> ovr_q && ovr_w_q)
    else $error("overrun not flagged");
  overrun_irq_a: assert property ( // RQ14
    done && ovr_w_q |=> !rx_irq_o)
    else $error("receive interrupt raised on overrun");
  out_idle_a: assert property ( // RQ20
    st_q == ST_IDLE && $past(st_q) == ST_IDLE |-> txd_q)
    else $error("serial output not idle high");
  cont_rx_a: assert property ( // RQ18
    rx_rd && cont_q && !start |=> !tbe_q)
    else $error("continuous receive did not clear buffer empty");
endmodule

/* File: design/clock_sync_serial_consts.svh */
`ifndef CLOCK_SYNC_SERIAL_CONSTS_SVH
`define CLOCK_SYNC_SERIAL_CONSTS_SVH
// ==========================================
// Register byte addresses
`define CSS_ADR_TXBUF   8'h00
`define CSS_ADR_RXBUF   8'h04
`define CSS_ADR_BRG     8'h08
`define CSS_ADR_MODE    8'h0c
`define CSS_ADR_CTRL0   8'h10
`define CSS_ADR_CTRL1   8'h14
`define CSS_ADR_PRESC   8'h18
// ==========================================
// Field positions
`define CSS_RX_OVR      8
`define CSS_MD_CKSRC    0
`define CSS_C0_CKS_LO   0
`define CSS_C0_CKS_HI   1
`define CSS_C0_CRS      2
`define CSS_C0_SHEMPTY  3
`define CSS_C0_CRD      4
`define CSS_C0_OD       5
`define CSS_C0_EDGE     6
`define CSS_C0_ORDER    7
`define CSS_C1_TE       0
`define CSS_C1_TBE      1
`define CSS_C1_RE       2
`define CSS_C1_RXF      3
`define CSS_C1_IRS      4
`define CSS_C1_CONT     5
`define CSS_C1_INV      6
// ==========================================
// Reset values and counts
`define CSS_RST_CRD     1'b1
`define CSS_RST_BYTE    8'h00
`define CSS_WORD_BITS   8
`define CSS_LAST_BIT    3'h7
`define CSS_OVR_BIT     3'h6
`define CSS_DIV8_LAST   3'h7
`endif

/* File: design/clock_sync_serial_pkg.sv */
package clock_sync_serial_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } xfer_state_type;
  typedef enum logic [1:0] {
    SRC_UNDIV = 2'b00,
    SRC_DIV8  = 2'b01,
    SRC_PRESC = 2'b10
  } src_sel_type;
endpackage

/* File: design/clk_src_div.sv */
`timescale 1ns/1ps
`include "clock_sync_serial_consts.svh"
module clk_src_div
  import clock_sync_serial_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [1:0] src_i,
  input  wire logic [3:0] presc_i,
  input  wire logic [7:0] div_i,
  output logic            tick_o
);
  logic [2:0] c8_q;
  logic [4:0] cp_q;
  logic [7:0] cb_q;
  wire logic [4:0] plim  = {presc_i, 1'b0} - 5'h01;
  wire logic       p8    = c8_q == `CSS_DIV8_LAST;
  wire logic       pn    = (presc_i == 4'h0) | (cp_q == plim);
  wire logic       src_e = (src_i == SRC_UNDIV) ? 1'b1 :
                           (src_i == SRC_DIV8) ? p8 : pn; // RQ3
  wire logic       top   = cb_q == div_i;
  // ==========================================
  // Source prescalers run free; the divider restarts per word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c8_q <= 3'h0;
      cp_q <= 5'h00;
    end else begin
      c8_q <= c8_q + 3'h1;
      cp_q <= pn ? 5'h00 : cp_q + 5'h01; // RQ3
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cb_q <= 8'h00;
    end else if (src_e) begin
      cb_q <= top ? 8'h00 : cb_q + 8'h01; // RQ2
    end
  end
  // One tick per half period: period is 2(m+1) source pulses
  assign tick_o = run_i & src_e & top; // RQ2
endmodule

/* File: design/pin_edge_detect.sv */
`timescale 1ns/1ps
module pin_edge_detect (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic prev_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= level_i;
    end
  end
  assign rise_o = level_i & ~prev_q;
  assign fall_o = ~level_i & prev_q;
endmodule

/* File: bench/serial_peer_model.sv */
`timescale 1ns/1ps
// ==========================================
// Far-side peer: shifts one byte each way on the shared clock
module serial_peer_model (
  input  wire logic       clk_i,
  input  wire logic       arm_i,
  input  wire logic       ext_i,
  input  wire logic       edge_i,
  input  wire logic       msb_i,
  input  wire logic [7:0] tx_i,
  input  wire logic       sclk_i,
  input  wire logic       sdo_i,
  output logic            pclk_o,
  output logic            sdi_o,
  output logic      [7:0] rx_o
);
  logic [3:0] idx;
  logic [4:0] run;
  logic [1:0] ph;
  logic [1:0] hold;

  initial begin
    idx = 4'h0;
    run = 5'h00;
    ph = 2'h0;
    hold = 2'h0;
    pclk_o = 1'b1;
    sdi_o = 1'b0;
    rx_o = 8'h00;
  end

  // ==========================================
  // External clock only toggles inside a frame
  always @(posedge clk_i) begin
    if (hold == 2'h1) begin
      sdi_o <= ~sdi_o;
    end
    if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end
    if (arm_i) begin
      idx <= 4'h0;
      run <= ext_i ? 5'h10 : 5'h00;
      ph  <= 2'h0;
    end else if (run != 5'h00) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        pclk_o <= ~pclk_o;
        run    <= run - 5'h01;
      end
    end else begin
      pclk_o <= ~edge_i;
    end
  end

  // ==========================================
  // Data changes on the drive edge and holds past the sample edge
  always @(sclk_i) begin
    if (sclk_i === edge_i && idx < 4'h8) begin
      sdi_o <= msb_i ? tx_i[3'h7 - idx[2:0]] : tx_i[idx[2:0]];
      idx   <= idx + 4'h1;
    end else if (sclk_i === ~edge_i && idx != 4'h0 && idx <= 4'h8) begin
      rx_o <= msb_i ? {rx_o[6:0], sdo_i} : {sdo_i, rx_o[7:1]};
      if (idx == 4'h8) begin
        // Released line shows the inverse so a stale value cannot pass
        hold <= 2'h3;
        idx  <= 4'h9;
      end
    end
  end
endmodule

/* File: bench/clock_sync_serial_channel_bench.sv */
`timescale 1ns/1ps
`include "clock_sync_serial_consts.svh"
module clock_sync_serial_channel_bench;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cts_n_i;
  logic        arm, ext, edge_sel, msb, pclk, sdi, wb_ack_o;
  logic        clk_pin_o, clk_pin_oe, sdo_pin, sdo_oe, rts_n_o, tx_irq_o, rx_irq_o;
  logic [7:0]  wb_adr_i, peer_tx, peer_rx;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  int          num_errors, checks, cyc_n, tx_cnt, rx_cnt, tx_t, rx_t;
  wire         sclk = clk_pin_oe ? clk_pin_o : pclk;
  // Open-drain data line carries a pull-up
  wire         sdo = sdo_oe ? sdo_pin : 1'b1;

  clock_sync_serial_channel dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serial_clock_pin_i(sclk), .serial_clock_pin_o(clk_pin_o),
    .serial_clock_pin_oe_o(clk_pin_oe), .serial_out_pin_o(sdo_pin),
    .serial_out_pin_oe_o(sdo_oe), .serial_in_pin_i(sdi), .cts_n_i(cts_n_i),
    .rts_n_o(rts_n_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));

  serial_peer_model peer (.clk_i(clk_i), .arm_i(arm), .ext_i(ext), .edge_i(edge_sel),
    .msb_i(msb), .tx_i(peer_tx), .sclk_i(sclk), .sdo_i(sdo), .pclk_o(pclk),
    .sdi_o(sdi), .rx_o(peer_rx));

  // ==========================================
  // Clock and event stamps
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (tx_irq_o === 1'b1) begin
      tx_cnt <= tx_cnt + 1;
      tx_t   <= cyc_n;
    end
    if (rx_irq_o === 1'b1) begin
      rx_cnt <= rx_cnt + 1;
      rx_t   <= cyc_n;
    end
  end

  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask

  task automatic wait_irq(input bit rx, input int n);
    int k;
    k = 0;
    while ((rx ? rx_cnt : tx_cnt) < n && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 3000) begin
      $display("Error irq wait expected %0d seen %0d", n, rx ? rx_cnt : tx_cnt);
      num_errors++;
    end
  endtask

  task automatic pulse_arm();
    arm <= 1'b1;
    @(posedge clk_i);
    arm <= 1'b0;
  endtask

  task automatic setup(input logic [7:0] c0, input logic [7:0] c1, input logic e,
                       input logic [7:0] pb);
    bus(1'b1, `CSS_ADR_CTRL1, 32'h0);
    ext      <= e;
    edge_sel <= c0[6];
    msb      <= c0[7];
    peer_tx  <= pb;
    bus(1'b1, `CSS_ADR_MODE, {31'h0, e});
    bus(1'b1, `CSS_ADR_BRG, 32'h1);
    bus(1'b1, `CSS_ADR_CTRL0, {24'h0, c0});
    bus(1'b1, `CSS_ADR_CTRL1, {24'h0, c1});
  endtask

  // Frame length follows the half period hp in clk cycles
  task automatic do_xfer(input logic [7:0] c0, input logic [7:0] c1, input logic e,
                         input logic [7:0] txb, input logic [7:0] pb, input int hp);
    int r;
    int t0;
    setup(c0, c1, e, pb);
    r = rx_cnt;
    if (!e) pulse_arm();
    bus(1'b1, `CSS_ADR_TXBUF, {24'h0, txb});
    t0 = cyc_n;
    if (e) pulse_arm();
    wait_irq(1, r + 1);
    chk("frame length", 1, (rx_t - t0 >= 15 * hp) && (rx_t - t0 <= 16 * hp + 8));
    chk("tx irq timing", {31'h0, c1[4]}, (tx_t + 4 >= rx_t));
    rdc("rx buffer", `CSS_ADR_RXBUF, 32'h1ff, {24'h0, c1[6] ? ~pb : pb});
    chk("peer byte", {24'h0, c1[6] ? ~txb : txb}, {24'h0, peer_rx});
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk("idle data line", 1, sdo);
    rdc("ctrl0 reset", `CSS_ADR_CTRL0, 32'hffffffff, 32'h18);
    rdc("ctrl1 reset", `CSS_ADR_CTRL1, 32'hffffffff, 32'h02);
    rdc("unmapped", 8'h1c, 32'hffffffff, 32'h0);
  endtask

  task automatic t_handshake();
    int r;
    setup(8'h04, 8'h04, 1'b0, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("rts level", 0, rts_n_o);
    cts_n_i <= 1'b1;
    setup(8'h00, 8'h05, 1'b0, 8'hc3);
    r = rx_cnt;
    pulse_arm();
    bus(1'b1, `CSS_ADR_TXBUF, 32'h5a);
    repeat (40) @(posedge clk_i);
    rdc("held tx empty", `CSS_ADR_CTRL1, 32'h2, 32'h0);
    cts_n_i <= 1'b0;
    wait_irq(1, r + 1);
    rdc("cts rx buffer", `CSS_ADR_RXBUF, 32'hff, 32'hc3);
  endtask

  task automatic t_overrun();
    int r;
    int n;
    do_xfer(8'h30, 8'h15, 1'b0, 8'h11, 8'h22, 2);
    chk("open drain idle", 0, sdo_oe);
    // Second word stays unread so the third one overruns it
    r = rx_cnt;
    pulse_arm();
    bus(1'b1, `CSS_ADR_TXBUF, 32'h33);
    wait_irq(1, r + 1);
    n = tx_cnt;
    pulse_arm();
    bus(1'b1, `CSS_ADR_TXBUF, 32'h44);
    wait_irq(0, n + 1);
    repeat (4) @(posedge clk_i);
    chk("rx irq count", r + 1, rx_cnt);
    rdc("overrun flag", `CSS_ADR_RXBUF, 32'h100, 32'h100);
  endtask

  task automatic t_cont();
    int r;
    setup(8'h10, 8'h05, 1'b0, 8'h6b);
    r = rx_cnt;
    pulse_arm();
    bus(1'b1, `CSS_ADR_TXBUF, 32'h0);
    // Continuous mode goes on only after the one trigger write
    bus(1'b1, `CSS_ADR_CTRL1, 32'h25);
    wait_irq(1, r + 1);
    peer_tx <= 8'hd4;
    pulse_arm();
    rdc("first word", `CSS_ADR_RXBUF, 32'hff, 32'h6b);
    wait_irq(1, r + 2);
    rdc("second word", `CSS_ADR_RXBUF, 32'hff, 32'hd4);
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, arm, ext, edge_sel, msb} = 7'h0;
    cts_n_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    peer_tx = 8'h00;
    {num_errors, checks, cyc_n, tx_cnt, rx_cnt, tx_t, rx_t} = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    bus(1'b1, `CSS_ADR_PRESC, 32'h3);
    do_xfer(8'h10, 8'h05, 1'b0, 8'ha5, 8'h3c, 2);
    do_xfer(8'hd1, 8'h55, 1'b0, 8'h96, 8'h4e, 16);
    do_xfer(8'h92, 8'h05, 1'b0, 8'h81, 8'h7e, 12);
    do_xfer(8'h10, 8'h05, 1'b1, 8'h5c, 8'he1, 4);
    t_handshake();
    t_overrun();
    t_cont();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end
endmodule
